// *** rtl/uart_engine.sv ***
// serial shift engine: synchronous shift mode and 10-bit asynchronous mode
// assumes timer1_overflow is a one-clock pulse from logic on the same clock
`default_nettype none

// ****************************************
// transmit fifo
// ****************************************
module tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_reg];

	// flags are registered so the top sees flop outputs
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				mem[wr_reg] <= in_data;
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			count_reg <= count_next;
			in_ready <= count_next != (AW+1)'(DEPTH);
			out_valid <= count_next != '0;
		end
	end
endmodule // tx_fifo

// ****************************************
// engine
// ****************************************
module uart_engine (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// transmit stream into the serial buffer
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// control writes
	input wire logic serial_ctrl_write,
	input wire uart_pkg::serial_ctrl_t serial_ctrl_data,
	input wire logic power_ctrl_write,
	input wire logic baud_double_bit,
	input wire logic timer1_overflow,
	// receive buffer and status
	output logic [7:0] serial_buffer,
	output uart_pkg::serial_status_t status,
	// pins
	output logic port1_pin_zero,
	input wire logic port1_pin_one_in,
	output logic port1_pin_one_out,
	output logic port1_pin_one_oe
);
	import uart_pkg::*;

	typedef struct packed {
		logic [3:0] phase;
		logic prescale;
		logic [3:0] tx_div;
		logic [3:0] rx_div;
		tx_state_t tx_state;
		logic [8:0] tx_shift;
		logic tx_last;
		rx_state_t rx_state;
		logic [8:0] rx_shift;
		logic rx_last;
		logic rx_first;
		logic [2:0] rx_samp;
		logic [2:0] sync;
		logic line;
		logic line_prev;
		logic [7:0] buffer;
		logic ninth;
		logic tx_done;
		logic rx_done;
		logic fe;
		logic baud_double;
		logic multiproc;
		logic rx_enable;
		mode_t mode;
		logic pin0;
		logic pin1_out;
		logic pin1_oe;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic pop;
	logic tick;
	logic tx_roll;
	logic rx_roll;
	logic rx_bit;
	logic sclk;

	function automatic logic [7:0] reverse8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction

	function automatic logic majority3(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// the fifo only drains while the transmitter is idle, so it really fills
	tx_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(tx_valid),
		.in_data(tx_data),
		.in_ready(tx_ready),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// write at s6p2 in shift mode
	assign pop = fifo_valid && st_reg.tx_state == TX_IDLE
		&& (st_reg.mode == MODE_ASYNC
		|| (st_reg.phase == PH_S6P2 && st_reg.rx_state == RX_IDLE));
	// double bit passes every overflow, else every second one
	assign tick = timer1_overflow && (st_reg.baud_double || st_reg.prescale);
	assign tx_roll = tick && st_reg.tx_div == DIV_LAST;
	assign rx_roll = tick && st_reg.rx_div == DIV_LAST;
	assign rx_bit = majority3(st_reg.rx_samp);
	// shift clock low in s3 through s5
	assign sclk = !(st_reg.phase >= PH_S3P1 && st_reg.phase <= PH_S5P2);

	always_comb begin
		st_next = st_reg;
		st_next.phase = (st_reg.phase == PH_LAST) ? '0 : st_reg.phase + 4'h1;
		if (timer1_overflow)
			st_next.prescale = !st_reg.prescale;
		if (tick)
			st_next.tx_div = st_reg.tx_div + 4'h1;
		// a change counts once the last two stages agree
		st_next.sync = {st_reg.sync[1:0], port1_pin_one_in};
		if (st_reg.sync[1] == st_reg.sync[2])
			st_next.line = st_reg.sync[2];
		st_next.line_prev = st_reg.line;
		// clears come first so a same-cycle set wins
		if (serial_ctrl_write) begin
			st_next.mode = serial_ctrl_data.mode;
			st_next.multiproc = serial_ctrl_data.multiproc_check_bit;
			st_next.rx_enable = serial_ctrl_data.rx_enable;
			if (!serial_ctrl_data.tx_done_keep)
				st_next.tx_done = 1'b0;
			if (!serial_ctrl_data.rx_done_keep)
				st_next.rx_done = 1'b0;
			if (!serial_ctrl_data.fe_keep)
				st_next.fe = 1'b0;
		end
		if (power_ctrl_write)
			st_next.baud_double = baud_double_bit;

		// ****************************************
		// transmitter
		// ****************************************
		unique case (st_reg.tx_state)
			TX_IDLE: begin
				// marker one in the ninth position
				if (pop) begin
					st_next.tx_shift = {1'b1, fifo_data};
					st_next.tx_state = TX_HOLD;
				end
			end
			TX_HOLD: begin
				if (st_reg.mode == MODE_SHIFT) begin
					// one full machine cycle before send
					if (st_reg.phase == PH_S6P2)
						st_next.tx_state = TX_SEND;
				end else if (tx_roll) begin
					st_next.tx_state = TX_ARMED;
				end
			end
			TX_ARMED: begin
				if (st_reg.phase == PH_S1P1)
					st_next.tx_state = TX_SEND;
			end
			TX_SEND: begin
				if (st_reg.mode == MODE_ASYNC) begin
					// start bit until the next divider rollover
					if (tx_roll)
						st_next.tx_state = TX_DATA;
				end else if (st_reg.tx_last) begin
					// done at s1p1 after the last shift
					if (st_reg.phase == PH_S1P1) begin
						st_next.tx_last = 1'b0;
						st_next.tx_state = TX_IDLE;
						st_next.tx_done = 1'b1;
					end
				// shift right, zeros from the left
				end else if (st_reg.phase == PH_S6P2) begin
					st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
					// only the marker position counts; bit zero holds the data msb
					st_next.tx_last = st_reg.tx_shift[8:1] == TX_MARK_END[8:1];
				end
			end
			TX_DATA: begin
				// first shift one bit time after data
				if (tx_roll) begin
					st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
					if (st_reg.tx_shift[8:1] == TX_MARK_END[8:1]) begin
						st_next.tx_state = TX_IDLE;
						st_next.tx_done = 1'b1;
					end
				end
			end
			default: st_next.tx_state = TX_IDLE;
		endcase

		// ****************************************
		// receiver
		// ****************************************
		unique case (st_reg.rx_state)
			RX_IDLE: begin
				if (st_reg.rx_enable && st_reg.mode == MODE_SHIFT) begin
					// start on enable with done clear
					if (!st_reg.rx_done && st_reg.phase == PH_S1P1
						&& st_reg.tx_state == TX_IDLE)
						st_next.rx_state = RX_ARM;
				end else if (st_reg.rx_enable && st_reg.line_prev && !st_reg.line) begin
					st_next.rx_div = '0;
					st_next.rx_shift = RX_ASYNC_INIT;
					st_next.rx_first = 1'b1;
					st_next.rx_state = RX_SHIFT;
				end
			end
			RX_ARM: begin
				// load pattern, receive from the next phase
				if (st_reg.phase == PH_S6P2) begin
					st_next.rx_shift = {1'b1, RX_SYNC_INIT};
					st_next.rx_state = RX_SHIFT;
				end
			end
			RX_SHIFT: begin
				if (st_reg.mode == MODE_SHIFT) begin
					// sample at s5p2, shift left at s6p2
					if (st_reg.phase == PH_S5P2)
						st_next.rx_samp[0] = st_reg.line;
					if (st_reg.rx_last) begin
						if (st_reg.phase == PH_S1P1) begin
							st_next.rx_last = 1'b0;
							st_next.rx_state = RX_IDLE;
							st_next.rx_done = 1'b1;
						end
					end else if (st_reg.phase == PH_S6P2) begin
						st_next.rx_shift = {st_reg.rx_shift[7:0], st_reg.rx_samp[0]};
						// zero at the left: last shift loads buffer
						if (!st_reg.rx_shift[7]) begin
							st_next.rx_last = 1'b1;
							st_next.buffer = reverse8({st_reg.rx_shift[6:0], st_reg.rx_samp[0]});
						end
					end
				end else begin
					// samples at counter states seven to nine
					if (tick) begin
						st_next.rx_div = st_reg.rx_div + 4'h1;
						if (st_reg.rx_div >= SAMPLE_FIRST && st_reg.rx_div <= SAMPLE_LAST)
							st_next.rx_samp = {st_reg.rx_samp[1:0], st_reg.line};
					end
					if (rx_roll) begin
						st_next.rx_shift = {st_reg.rx_shift[7:0], rx_bit};
						st_next.rx_first = 1'b0;
						// false start goes back to watching
						if (st_reg.rx_first && rx_bit) begin
							st_next.rx_state = RX_IDLE;
						// start bit at the left: final shift
						end else if (!st_reg.rx_first && !st_reg.rx_shift[8]) begin
							// back to edge search either way
							st_next.rx_state = RX_IDLE;
							if (!rx_bit)
								st_next.fe = 1'b1;
							if (!st_reg.rx_done && (!st_reg.multiproc || rx_bit)) begin
								// stop bit into the ninth bit flag
								st_next.buffer = reverse8(st_reg.rx_shift[7:0]);
								st_next.ninth = rx_bit;
								st_next.rx_done = 1'b1;
							end
						end
					end
				end
			end
			default: st_next.rx_state = RX_IDLE;
		endcase

		// ****************************************
		// pins
		// ****************************************
		if (st_reg.mode == MODE_SHIFT) begin
			// data on pin one, shift clock on pin zero
			st_next.pin0 = (st_reg.tx_state == TX_SEND || st_reg.rx_state == RX_SHIFT)
				? sclk : 1'b1;
			st_next.pin1_out = st_reg.tx_shift[0];
			st_next.pin1_oe = st_reg.tx_state == TX_SEND;
		end else begin
			// start bit low, then the shift output
			st_next.pin0 = (st_reg.tx_state == TX_SEND) ? 1'b0
				: (st_reg.tx_state == TX_DATA) ? st_reg.tx_shift[0] : 1'b1;
			st_next.pin1_out = 1'b1;
			st_next.pin1_oe = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_reg <= '0;
			// baud double cleared by the zero reset
			st_reg.sync <= 3'h7;
			st_reg.line <= 1'b1;
			st_reg.line_prev <= 1'b1;
			st_reg.pin0 <= 1'b1;
			st_reg.pin1_out <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// the read side only ever shows the receive buffer
	assign serial_buffer = st_reg.buffer;
	assign status = '{st_reg.tx_done, st_reg.rx_done, st_reg.ninth, st_reg.fe,
		st_reg.baud_double};
	assign port1_pin_zero = st_reg.pin0;
	assign port1_pin_one_out = st_reg.pin1_out;
	assign port1_pin_one_oe = st_reg.pin1_oe;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_sclk_low_state: assert property (
		(st_reg.mode == MODE_SHIFT && st_reg.tx_state == TX_SEND
		&& st_reg.phase == PH_S5P2) |=> !port1_pin_zero)
		else $error("shift clock not low in s5");
	a_send_after_cycle: assert property (
		(pop && st_reg.mode == MODE_SHIFT) |-> ##13 st_reg.tx_state == TX_SEND)
		else $error("send not one machine cycle after write");
	a_tx_shift_right: assert property (
		(st_reg.mode == MODE_SHIFT && st_reg.tx_state == TX_SEND && !st_reg.tx_last
		&& st_reg.phase == PH_S6P2) |=> st_reg.tx_shift == {1'b0, $past(st_reg.tx_shift[8:1])})
		else $error("transmit shift wrong");
	a_tx_done_s1p1: assert property (
		(st_reg.tx_state == TX_SEND && st_reg.tx_last && st_reg.phase == PH_S1P1)
		|=> st_reg.tx_done && st_reg.tx_state == TX_IDLE)
		else $error("transmit done missing");
	a_rx_load_pattern: assert property (
		(st_reg.rx_state == RX_ARM && st_reg.phase == PH_S6P2)
		|=> st_reg.rx_state == RX_SHIFT && st_reg.rx_shift[7:0] == RX_SYNC_INIT)
		else $error("receive pattern not loaded");
	a_start_bit_low: assert property (
		(st_reg.mode == MODE_ASYNC && st_reg.tx_state == TX_SEND) |=> !port1_pin_zero)
		else $error("start bit not low");
	a_edge_resets_div: assert property (
		(st_reg.mode == MODE_ASYNC && st_reg.rx_state == RX_IDLE && st_reg.rx_enable
		&& st_reg.line_prev && !st_reg.line)
		|=> st_reg.rx_div == '0 && st_reg.rx_shift == RX_ASYNC_INIT)
		else $error("edge did not restart receiver");
	a_false_start: assert property (
		(st_reg.mode == MODE_ASYNC && st_reg.rx_state == RX_SHIFT && st_reg.rx_first
		&& rx_roll && rx_bit) |=> st_reg.rx_state == RX_IDLE)
		else $error("false start accepted");
	a_load_blocked: assert property (
		(st_reg.mode == MODE_ASYNC && st_reg.rx_state == RX_SHIFT && rx_roll
		&& st_reg.rx_done) |=> $stable(serial_buffer))
		else $error("buffer overwritten while done set");
	a_fe_sticky: assert property (
		(st_reg.fe && !(serial_ctrl_write && !serial_ctrl_data.fe_keep)) |=> st_reg.fe)
		else $error("framing error lost");
endmodule // uart_engine
`default_nettype wire

// *** inc/uart_pkg.sv ***
// constants and types shared by the serial shift engine
// assumes one 20 MHz clock; each clock is one phase of a machine cycle
`default_nettype none
package uart_pkg;
	// ****************************************
	// machine cycle: six states of two phases
	// ****************************************
	localparam logic [3:0] PH_S1P1 = 4'h0;
	localparam logic [3:0] PH_S3P1 = 4'h4;
	localparam logic [3:0] PH_S5P2 = 4'h9;
	localparam logic [3:0] PH_S6P2 = 4'hb;
	localparam logic [3:0] PH_LAST = 4'hb;
	// ****************************************
	// shift register patterns and counter states
	// ****************************************
	localparam logic [8:0] TX_MARK_END = 9'h003;
	localparam logic [7:0] RX_SYNC_INIT = 8'hfe;
	localparam logic [8:0] RX_ASYNC_INIT = 9'h1ff;
	localparam logic [3:0] DIV_LAST = 4'hf;
	localparam logic [3:0] SAMPLE_FIRST = 4'h7;
	localparam logic [3:0] SAMPLE_LAST = 4'h9;
	localparam int TX_FIFO_DEPTH = 4;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic {MODE_SHIFT, MODE_ASYNC} mode_t;
	typedef enum logic [2:0] {TX_IDLE, TX_HOLD, TX_ARMED, TX_SEND, TX_DATA} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_ARM, RX_SHIFT} rx_state_t;
	typedef struct packed {
		mode_t mode;
		logic multiproc_check_bit;
		logic rx_enable;
		logic tx_done_keep;
		logic rx_done_keep;
		logic fe_keep;
	} serial_ctrl_t;
	typedef struct packed {
		logic tx_done_flag;
		logic rx_done_flag;
		logic rx_ninth_bit;
		logic framing_error_flag;
		logic baud_double_bit;
	} serial_status_t;
endpackage
`default_nettype wire

// *** test/serial_partner.sv ***
// far side model: remote asynchronous transceiver and external shift register
// assumes the bench resolves the shared data pin and pulses send_go at a falling edge
`default_nettype none
module serial_partner #(
	parameter int BIT_CLKS = 64
) (
	// clock
	input wire logic clock,
	// lines from the engine
	input wire logic line_from_dut,
	input wire logic data_from_dut,
	input wire logic data_oe,
	input wire logic shift_mode,
	// frame to send: start, eight data, stop
	input wire logic send_go,
	input wire logic [9:0] send_frame,
	// line towards the engine and captured shift data
	output logic line_to_dut,
	output logic [7:0] shift_got
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q[$];
	logic got_stop = 1'b0;
	logic line_async = 1'b1;
	logic [7:0] shift_out = 8'h00;
	logic [8:0] rx_bits;
	assign line_to_dut = shift_mode ? shift_out[0] : line_async;
	// frame out: start, data lsb first, stop
	always @(posedge send_go) begin
		if (shift_mode) begin
			shift_out = send_frame[8:1];
		end else begin
			for (int i = 0; i < 10; i++) begin
				line_async <= send_frame[i];
				repeat (BIT_CLKS) @(posedge clock);
			end
			line_async <= 1'b1;
		end
	end
	// frame in: sample each bit at its centre
	always begin
		@(negedge line_from_dut);
		if (!shift_mode) begin
			repeat (BIT_CLKS / 2) @(posedge clock);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CLKS) @(posedge clock);
				rx_bits[i] = line_from_dut;
			end
			got_q.push_back(rx_bits[7:0]);
			got_stop = rx_bits[8];
		end
	end
	// external register: acts on the rising shift clock
	always @(posedge line_from_dut) begin
		if (shift_mode && data_oe) begin
			shift_got <= {data_from_dut, shift_got[7:1]};
		end else if (shift_mode) begin
			// spent bits come back inverted so a stale value is never read as fresh
			shift_out <= {~shift_out[0], shift_out[7:1]};
		end
	end
endmodule // serial_partner
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the serial shift engine in both modes
// assumes uart_pkg compiled first; timer overflow pulses every 4 clocks
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// signals
	// ****
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_ready;
	logic serial_ctrl_write = 1'b0;
	uart_pkg::serial_ctrl_t serial_ctrl_data = '0;
	logic power_ctrl_write = 1'b0;
	logic baud_double_bit = 1'b0;
	logic timer1_overflow = 1'b0;
	logic [1:0] tick_cnt = 2'h0;
	logic [7:0] serial_buffer;
	uart_pkg::serial_status_t status;
	logic pin0, pin1_in, pin1_out, pin1_oe, partner_line;
	logic shift_mode = 1'b1;
	logic glitch_n = 1'b1;
	logic send_go = 1'b0;
	logic [9:0] send_frame = 10'h3ff;
	logic full_seen;
	logic [7:0] bytes[$];
	int num_errors = 0;
	int checks_done = 0;
	int n;
	always #25 clock = ~clock;
	always @(negedge clock) begin
		tick_cnt <= tick_cnt + 2'h1;
		timer1_overflow <= (tick_cnt == 2'h3);
	end
	assign pin1_in = pin1_oe ? pin1_out : (glitch_n & partner_line);
	uart_engine uart_engine_i (.clock(clock), .resetn(resetn), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .serial_ctrl_write(serial_ctrl_write),
		.serial_ctrl_data(serial_ctrl_data), .power_ctrl_write(power_ctrl_write),
		.baud_double_bit(baud_double_bit), .timer1_overflow(timer1_overflow),
		.serial_buffer(serial_buffer), .status(status), .port1_pin_zero(pin0),
		.port1_pin_one_in(pin1_in), .port1_pin_one_out(pin1_out), .port1_pin_one_oe(pin1_oe));
	serial_partner #(.BIT_CLKS(64)) serial_partner_i (.clock(clock), .line_from_dut(pin0),
		.data_from_dut(pin1_out), .data_oe(pin1_oe), .shift_mode(shift_mode),
		.send_go(send_go), .send_frame(send_frame), .line_to_dut(partner_line),
		.shift_got());
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		if (num_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// sel 0 waits for tx done, 1 for rx done, k+2 for k frames at the partner
	task automatic wait_for(input int sel, input int lim);
		n = 0;
		while (!((sel == 0 && status.tx_done_flag === 1'b1)
			|| (sel == 1 && status.rx_done_flag === 1'b1)
			|| (sel >= 2 && serial_partner_i.got_q.size() >= sel - 2))) begin
			@(negedge clock);
			n++;
			if (n > lim) begin
				num_errors++;
				report_and_stop();
			end
		end
	endtask
	task automatic ctrl(input logic [5:0] v);
		serial_ctrl_data = v;
		serial_ctrl_write = 1'b1;
		shift_mode = ~v[5];
		@(negedge clock);
		serial_ctrl_write = 1'b0;
		@(negedge clock);
	endtask
	task automatic send(input logic [9:0] f);
		send_frame = f;
		send_go = 1'b1;
		@(negedge clock);
		send_go = 1'b0;
	endtask
	// valid stays up between bytes; each is taken at the edge where ready is high
	task automatic push_bytes(input logic [7:0] q[$]);
		full_seen = 1'b0;
		foreach (q[i]) begin
			tx_data = q[i];
			tx_valid = 1'b1;
			for (int k = 0; tx_ready !== 1'b1; k++) begin
				full_seen = 1'b1;
				@(negedge clock);
				if (k > 2000) begin
					num_errors++;
					report_and_stop();
				end
			end
			@(negedge clock);
		end
		tx_valid = 1'b0;
	endtask
	// ****
	// scenarios
	// ****
	task automatic shift_tx;
		ctrl(6'h07);
		push_bytes({8'ha5});
		wait_for(0, 200);
		chk(serial_partner_i.shift_got, 8'ha5);
		chk(n >= 96 && n <= 124, 1'b1);
		ctrl(6'h03);
		chk(status.tx_done_flag, 1'b0);
	endtask
	task automatic shift_rx;
		send({1'b1, 8'h3c, 1'b0});
		ctrl(6'h0b);
		wait_for(1, 200);
		chk(serial_buffer, 8'h3c);
		chk(n <= 140, 1'b1);
	endtask
	task automatic async_tx;
		ctrl(6'h27);
		baud_double_bit = 1'b1;
		power_ctrl_write = 1'b1;
		@(negedge clock);
		power_ctrl_write = 1'b0;
		@(negedge clock);
		chk(status.baud_double_bit, 1'b1);
		bytes = {8'h11, 8'h22, 8'ha5, 8'h5a, 8'hc3, 8'h3c};
		push_bytes(bytes);
		chk(full_seen, 1'b1);
		ctrl(6'h23);
		chk(status.tx_done_flag, 1'b0);
		wait_for(0, 800);
		chk(n >= 600 && n <= 660, 1'b1);
		wait_for(8, 6000);
		foreach (bytes[i]) chk(serial_partner_i.got_q[i], bytes[i]);
		chk(serial_partner_i.got_stop, 1'b1);
		wait_for(0, 800);
		chk(status.tx_done_flag, 1'b1);
	endtask
	task automatic async_rx;
		ctrl(6'h2d);
		send({1'b1, 8'h96, 1'b0});
		wait_for(1, 900);
		chk({serial_buffer, status.rx_ninth_bit, status.framing_error_flag},
			{8'h96, 2'h2});
		send({1'b1, 8'h11, 1'b0});
		repeat (700) @(negedge clock);
		chk(serial_buffer, 8'h96);
		ctrl(6'h3d);
		send({1'b0, 8'h44, 1'b0});
		repeat (700) @(negedge clock);
		chk({serial_buffer, status.rx_done_flag, status.framing_error_flag},
			{8'h96, 2'h1});
	endtask
	task automatic false_start;
		ctrl(6'h2f);
		glitch_n = 1'b0;
		repeat (8) @(negedge clock);
		glitch_n = 1'b1;
		repeat (100) @(negedge clock);
		chk(status.rx_done_flag, 1'b0);
		send({1'b1, 8'h69, 1'b0});
		wait_for(1, 900);
		chk({serial_buffer, status.framing_error_flag}, {8'h69, 1'b1});
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		@(negedge clock);
		chk({status, pin0, pin1_oe, serial_buffer}, {5'h00, 2'h2, 8'h00});
		shift_tx();
		shift_rx();
		async_tx();
		async_rx();
		false_start();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
